// ==== rtl/dch_defines.svh ====
// Purpose: shared constants of the dog cradle homing sequencer
// Assumes: homing method digit in the low nibble of the method config
// Notes:   timing counts derived from a 50 MHz clock
`ifndef DCH_DEFINES_SVH
`define DCH_DEFINES_SVH
// ----------------------------------------------------------------
// method config fields
// ----------------------------------------------------------------
`define DCH_METHOD_LSB      0
`define DCH_METHOD_MSB      3
`define DCH_DIR_BIT         4
`define DCH_DOGPOL_BIT      8
`define DCH_METHOD_CRADLE   4'h7
`define DCH_CFG_RESET       12'h000
// ----------------------------------------------------------------
// timing and warning code
// ----------------------------------------------------------------
`define DCH_CLK_MHZ         50
`define DCH_FILT_UNIT_NS    1000
`define DCH_FILT_UNIT_CYC   ((`DCH_FILT_UNIT_NS * `DCH_CLK_MHZ + 999) / 1000)
`define DCH_WARN_INCOMPLETE 12'h902
`endif

// ==== rtl/dch_pkg.sv ====
// Purpose: types of the dog cradle homing sequencer
// Assumes: nothing
// Notes:   state enum only
package dch_pkg;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RET_OFF,
    ST_SEEK_OUT,
    ST_SEEK_BACK,
    ST_FAST,
    ST_CREEP,
    ST_SHIFT,
    ST_STOP,
    ST_DONE,
    ST_FAIL
  } dch_state_t;
endpackage : dch_pkg

// ==== rtl/dch_in_filter.sv ====
// Purpose: synchroniser plus debounce for one external input
// Assumes: filter length in units of one microsecond
// Notes:   three flops, change counted when last two agree
`timescale 1ns/1ps
`include "dch_defines.svh"
module dch_in_filter #(
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  // filter length in microseconds
  input  wire logic [3:0]    filt_us,
  // pin and filtered level
  input  wire logic          pin,
  output logic               level
);
  typedef struct packed {
    logic [2:0]    sync;
    logic [CW-1:0] cnt;
    logic          lvl;
  } dch_flt_t;
  dch_flt_t s_r, s_nxt;
  logic [CW-1:0] limit;
  assign limit = CW'(filt_us) * CW'(`DCH_FILT_UNIT_CYC);
  // --------------------------------------------------------------
  // next state: delay change by filter time
  // --------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[1:0], pin};
    if (s_r.sync[2] != s_r.sync[1] || s_r.sync[1] == s_r.lvl) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt >= limit) begin
      s_nxt.lvl = s_r.sync[1];
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
  end
  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
  assign level = s_r.lvl;
endmodule : dch_in_filter

// ==== rtl/dch_ramp.sv ====
// Purpose: speed ramp toward a target speed
// Assumes: time constant + 1 = cycles per speed step
// Notes:   all speed changes pass through here
`timescale 1ns/1ps
module dch_ramp #(
  parameter int SW = 16,
  parameter int TW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  // target and time constant
  input  wire logic [SW-1:0] target,
  input  wire logic [TW-1:0] tc,
  // ramped speed
  output logic [SW-1:0]      speed
);
  typedef struct packed {
    logic [TW-1:0] div;
    logic [SW-1:0] spd;
  } dch_rmp_t;
  dch_rmp_t s_r, s_nxt;
  // --------------------------------------------------------------
  // one step each tc+1 cycles
  // --------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (s_r.spd == target) begin
      s_nxt.div = '0;
    end else if (s_r.div >= tc) begin
      s_nxt.div = '0;
      s_nxt.spd = (s_r.spd < target) ? s_r.spd + SW'(1) : s_r.spd - SW'(1);
    end else begin
      s_nxt.div = s_r.div + TW'(1);
    end
  end
  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
  assign speed = s_r.spd;
endmodule : dch_ramp

// ==== rtl/dch_sequencer.sv ====
// Purpose: dog cradle homing sequencer with automatic return
// Assumes: encoder index and position counts come from the drive
// Notes:
`timescale 1ns/1ps
`include "dch_defines.svh"
module dch_sequencer #(
  parameter int PW = 32,
  parameter int SW = 16,
  parameter int TW = 16
) (
  // clock, reset, enable
  input  wire logic          MCLK,
  input  wire logic          RST_B,
  input  wire logic          CE,
  // host selection pins
  input  wire logic          AUTO_MANUAL_SELECT,
  input  wire logic          TABLE_SELECT_BIT0,
  input  wire logic          TABLE_SELECT_BIT1,
  input  wire logic          TABLE_SELECT_BIT2,
  input  wire logic          PROGRAM_MODE,
  input  wire logic          PROGRAM_HOME_RETURN_COMMAND,
  input  wire logic          START,
  // sensor pins
  input  wire logic          PROXIMITY_DOG,
  input  wire logic          FORWARD_STROKE_LIMIT,
  input  wire logic          REVERSE_STROKE_LIMIT,
  // encoder, same clock domain
  input  wire logic          ENC_INDEX,
  input  wire logic [PW-1:0] ENC_POSITION,
  // settings (power-cycle)
  input  wire logic [11:0]   HOMING_METHOD_CONFIG,
  input  wire logic [SW-1:0] HOMING_SPEED_SETTING,
  input  wire logic [SW-1:0] CREEP_SPEED_SETTING,
  input  wire logic [PW-1:0] HOME_SHIFT_DISTANCE,
  input  wire logic [TW-1:0] HOMING_ACCEL_TIME_CONSTANT,
  input  wire logic [PW-1:0] HOME_POSITION_VALUE,
  input  wire logic [3:0]    INPUT_FILTER_TIME,
  // motion and status outputs
  output logic [SW-1:0]      SPEED_CMD,
  output logic               DIR_CMD,
  output logic               MOVING,
  output logic               SOFT_LIMIT_EN,
  output logic               HOME_DONE,
  output logic [11:0]        WARNING_CODE,
  output logic [PW-1:0]      CURRENT_POSITION
);
  typedef struct packed {
    dch_pkg::dch_state_t st;
    logic                dir;
    logic [PW-1:0]       target;
    logic [PW-1:0]       pos;
    logic                done;
    logic [11:0]         warn;
    logic [SW-1:0]       tgt_spd;
    logic                dog_d;
    logic                start_d;
    logic                move;
  } dch_seq_t;
  typedef struct packed {
    logic [11:0]   mcfg;
    logic [SW-1:0] hspd;
    logic [SW-1:0] cspd;
    logic [PW-1:0] shift;
    logic [TW-1:0] tc;
    logic [PW-1:0] hpos;
    logic [3:0]    filt;
    logic          loaded;
  } dch_cfg_t;
  dch_seq_t s_r, s_nxt;
  dch_cfg_t c_r;
  logic [1:0] rst_sync_r;
  logic       rst_i;
  logic       dog_f, lsp_f, lsn_f, start_f;
  logic       dog_on, dog_rise, start_rise, sel_home, lim_fwd_dir;
  logic       dir_home;
  logic [SW-1:0] ramp_spd;
  logic [PW-1:0] ret_pos;

  // ----------------------------------------------------------------
  // reset release through two flops
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_i = rst_sync_r[1];

  // ----------------------------------------------------------------
  // settings caught once after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_i) begin
    if (!rst_i) begin
      c_r <= '0;
    end else if (CE && !c_r.loaded) begin
      c_r.mcfg   <= HOMING_METHOD_CONFIG;
      c_r.hspd   <= HOMING_SPEED_SETTING;
      c_r.cspd   <= CREEP_SPEED_SETTING;
      c_r.shift  <= HOME_SHIFT_DISTANCE;
      c_r.tc     <= HOMING_ACCEL_TIME_CONSTANT;
      c_r.hpos   <= HOME_POSITION_VALUE;
      c_r.filt   <= INPUT_FILTER_TIME;
      c_r.loaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // input filters for external pins
  // ----------------------------------------------------------------
  localparam int NIN = 4;
  logic [NIN-1:0] pins_raw, pins_flt;
  assign pins_raw = {START, REVERSE_STROKE_LIMIT, FORWARD_STROKE_LIMIT, PROXIMITY_DOG};
  generate
    for (genvar gi = 0; gi < NIN; gi++) begin : g_flt
      dch_in_filter #(.CW(16)) u_flt (
        .clk     (MCLK),
        .rst_b   (rst_i),
        .ce      (CE),
        .filt_us (c_r.filt),
        .pin     (pins_raw[gi]),
        .level   (pins_flt[gi])
      );
    end
  endgenerate
  assign dog_f   = pins_flt[0] ^ c_r.mcfg[`DCH_DOGPOL_BIT]; // dog polarity from config
  assign lsp_f   = pins_flt[1];
  assign lsn_f   = pins_flt[2];
  assign start_f = pins_flt[3];

  // speed ramp
  dch_ramp #(.SW(SW), .TW(TW)) u_ramp (
    .clk    (MCLK),
    .rst_b  (rst_i),
    .ce     (CE),
    .target (s_r.tgt_spd),
    .tc     (c_r.tc),
    .speed  (ramp_spd)
  );
  // limit that lies ahead in a given direction (1 = forward)
  function automatic logic limit_ahead(input logic d, input logic lf, input logic lr);
    limit_ahead = d ? lf : lr;
  endfunction : limit_ahead

  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  assign dog_on      = dog_f;
  assign dog_rise    = dog_f & ~s_r.dog_d;
  assign start_rise  = start_f & ~s_r.start_d;
  assign dir_home    = c_r.mcfg[`DCH_DIR_BIT];
  // host must pick home return, either way
  assign sel_home    = AUTO_MANUAL_SELECT &
                       (PROGRAM_MODE ? PROGRAM_HOME_RETURN_COMMAND
                                     : ~(TABLE_SELECT_BIT0 | TABLE_SELECT_BIT1 | TABLE_SELECT_BIT2));
  assign lim_fwd_dir = limit_ahead(s_r.dir, lsp_f, lsn_f);
  assign ret_pos     = ENC_POSITION + c_r.shift;

  // ----------------------------------------------------------------
  // homing state machine
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.dog_d   = dog_f;
    s_nxt.start_d = start_f;
    s_nxt.pos     = ENC_POSITION;
    case (s_r.st)
      dch_pkg::ST_IDLE: begin
        s_nxt.pos  = s_r.pos;
        s_nxt.move = 1'b0;
        if (start_rise && sel_home && c_r.loaded &&
            c_r.mcfg[`DCH_METHOD_MSB:`DCH_METHOD_LSB] == `DCH_METHOD_CRADLE) begin
          s_nxt.done    = 1'b0;
          s_nxt.warn    = 12'h000;
          s_nxt.move    = 1'b1;
          s_nxt.tgt_spd = c_r.hspd;
          if (dog_on) begin
            s_nxt.dir = ~dir_home; // back off the dog first
            s_nxt.st  = dch_pkg::ST_RET_OFF;
          end else begin
            s_nxt.dir = dir_home;
            s_nxt.st  = dch_pkg::ST_SEEK_OUT;
          end
        end
      end
      dch_pkg::ST_RET_OFF: begin
        if (!dog_on) begin // off the dog: home normally
          s_nxt.dir = dir_home;
          s_nxt.st  = dch_pkg::ST_FAST;
        end else if (lim_fwd_dir) begin
          s_nxt.dir = ~s_r.dir;
        end
      end
      dch_pkg::ST_SEEK_OUT: begin
        if (dog_rise) begin
          s_nxt.tgt_spd = c_r.cspd;
          s_nxt.st      = dch_pkg::ST_CREEP;
        end else if (lim_fwd_dir) begin
          s_nxt.dir = ~s_r.dir;
          s_nxt.st  = dch_pkg::ST_SEEK_BACK;
        end
      end
      dch_pkg::ST_SEEK_BACK: begin
        if (dog_rise) begin
          s_nxt.st = dch_pkg::ST_RET_OFF; // wait to pass the front end
        end else if (lim_fwd_dir) begin
          s_nxt.tgt_spd = '0;
          s_nxt.move    = 1'b0;
          s_nxt.warn    = `DCH_WARN_INCOMPLETE;
          s_nxt.st      = dch_pkg::ST_FAIL;
        end
      end
      dch_pkg::ST_FAST: begin
        if (dog_rise) begin
          s_nxt.tgt_spd = c_r.cspd;
          s_nxt.st      = dch_pkg::ST_CREEP;
        end else if (lim_fwd_dir) begin
          s_nxt.tgt_spd = '0;
          s_nxt.move    = 1'b0;
          s_nxt.warn    = `DCH_WARN_INCOMPLETE;
          s_nxt.st      = dch_pkg::ST_FAIL;
        end
      end
      dch_pkg::ST_CREEP: begin
        if (ENC_INDEX) begin // first index after dog
          s_nxt.target = ret_pos;
          s_nxt.st     = dch_pkg::ST_SHIFT;
        end
      end
      dch_pkg::ST_SHIFT: begin
        if ((s_r.dir && ENC_POSITION >= s_r.target) ||
            (!s_r.dir && ENC_POSITION <= s_r.target)) begin
          s_nxt.tgt_spd = '0;
          s_nxt.st      = dch_pkg::ST_STOP;
        end
      end
      dch_pkg::ST_STOP: begin
        if (ramp_spd == '0) begin
          s_nxt.move = 1'b0;
          s_nxt.pos  = c_r.hpos;
          s_nxt.done = 1'b1;
          s_nxt.st   = dch_pkg::ST_DONE;
        end
      end
      dch_pkg::ST_DONE: begin
        s_nxt.pos = s_r.pos;
        s_nxt.st  = dch_pkg::ST_IDLE;
      end
      dch_pkg::ST_FAIL: begin
        if (ramp_spd == '0) begin
          s_nxt.st = dch_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = dch_pkg::ST_IDLE;
      end
    endcase
  end
  // state register
  always_ff @(posedge MCLK or negedge rst_i) begin
    if (!rst_i) begin
      s_r <= '0;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [SW-1:0] spd_o_r;
  logic          sl_o_r;
  always_ff @(posedge MCLK or negedge rst_i) begin
    if (!rst_i) begin
      spd_o_r <= '0;
      sl_o_r  <= 1'b0;
    end else if (CE) begin
      spd_o_r <= ramp_spd;
      // soft limits off from the cycle after the sequencer starts moving
      sl_o_r  <= ~s_r.move;
    end
  end
  assign SPEED_CMD        = spd_o_r;
  assign DIR_CMD          = s_r.dir;
  assign MOVING           = s_r.move;
  assign SOFT_LIMIT_EN    = sl_o_r;
  assign HOME_DONE        = s_r.done;
  assign WARNING_CODE     = s_r.warn;
  assign CURRENT_POSITION = s_r.pos;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  done_sets_pos_a: assert property (@(posedge MCLK) disable iff (!rst_i)
    CE && s_r.st == dch_pkg::ST_STOP && s_nxt.st == dch_pkg::ST_DONE |=> CURRENT_POSITION == c_r.hpos && HOME_DONE)
    else $error("home position not loaded");
  creep_speed_a: assert property (@(posedge MCLK) disable iff (!rst_i)
    s_r.st == dch_pkg::ST_CREEP |-> s_r.tgt_spd == c_r.cspd)
    else $error("creep speed not used");
  fail_warn_a: assert property (@(posedge MCLK) disable iff (!rst_i)
    s_r.st == dch_pkg::ST_FAIL |-> WARNING_CODE == `DCH_WARN_INCOMPLETE && !MOVING)
    else $error("incomplete warning missing");
  soft_limit_a: assert property (@(posedge MCLK) disable iff (!rst_i)
    CE && MOVING |=> !SOFT_LIMIT_EN)
    else $error("soft limit active during homing");
  method_gate_a: assert property (@(posedge MCLK) disable iff (!rst_i)
    s_r.st == dch_pkg::ST_IDLE && s_nxt.st != dch_pkg::ST_IDLE |->
    c_r.mcfg[`DCH_METHOD_MSB:`DCH_METHOD_LSB] == `DCH_METHOD_CRADLE)
    else $error("homing started with wrong method");
  start_clear_a: assert property (@(posedge MCLK) disable iff (!rst_i)
    CE && s_r.st == dch_pkg::ST_IDLE && s_nxt.st != dch_pkg::ST_IDLE |=> !HOME_DONE)
    else $error("done not cleared at start");
  cfg_frozen_a: assert property (@(posedge MCLK) disable iff (!rst_i)
    c_r.loaded |=> $stable(c_r.mcfg) && $stable(c_r.hpos))
    else $error("setting changed without restart");
  index_shift_a: assert property (@(posedge MCLK) disable iff (!rst_i)
    CE && s_r.st == dch_pkg::ST_CREEP && ENC_INDEX |=> s_r.target == $past(ENC_POSITION) + c_r.shift)
    else $error("shift target wrong");
endmodule : dch_sequencer

// ==== sim/dch_axis_model.sv ====
// Purpose: axis model: position, proximity dog, stroke limits, index pulse
// Assumes: position moves by the speed command on every clock
// Notes:   also watches the speed ramp for the bench
`timescale 1ns/1ps
module dch_axis_model #(
  parameter int DOG_LO = 2000,
  parameter int DOG_HI = 4000,
  parameter int LIM_F  = 6000,
  parameter int LIM_R  = -2000
) (
  // clock
  input  wire logic        clk,
  // motion command
  input  wire logic [15:0] speed,
  input  wire logic        dir,
  // bench control
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        dog_en,
  // sensors and encoder
  output logic             dog,
  output logic             fwd_lim,
  output logic             rev_lim,
  output logic             index,
  output logic [31:0]      pos,
  // ramp observations
  output logic             ramp_bad,
  output logic [15:0]      max_speed,
  output logic [15:0]      idx_speed
);
  logic [31:0] nxt;
  logic [15:0] prev;
  logic        chg_prev;
  // ----------------------------------------------------------------
  // travel
  // ----------------------------------------------------------------
  // next position from the command
  always_comb begin
    if (load) nxt = load_val;
    else if (dir) nxt = pos + {16'h0000, speed};
    else nxt = pos - {16'h0000, speed};
  end
  // one index pulse per 1024-count boundary crossed
  always_ff @(posedge clk) begin
    pos   <= nxt;
    index <= !load && (nxt[31:10] != pos[31:10]);
  end
  // sensors straight from the position
  assign dog     = dog_en && $signed(pos) >= DOG_LO && $signed(pos) <= DOG_HI;
  assign fwd_lim = $signed(pos) >= LIM_F;
  assign rev_lim = $signed(pos) <= LIM_R;
  // ----------------------------------------------------------------
  // ramp watch
  // ----------------------------------------------------------------
  // flags a step above one unit or two steps in adjacent cycles
  always_ff @(posedge clk) begin
    prev     <= speed;
    chg_prev <= (speed != prev);
    if (load) begin
      ramp_bad  <= 1'b0;
      max_speed <= 16'h0000;
      idx_speed <= 16'h0000;
    end else begin
      if (speed != prev && (chg_prev || speed > prev + 16'h0001 || prev > speed + 16'h0001)) ramp_bad <= 1'b1;
      if (speed > max_speed) max_speed <= speed;
      if (index && speed != 16'h0000) idx_speed <= speed;
    end
  end
endmodule : dch_axis_model

// ==== sim/testbench.sv ====
// Purpose: self-checking bench of the dog cradle homing sequencer
// Assumes: axis model closes the loop, filter time 1 us, tc 1
// Notes:   settings are changed before a reset, or after one on purpose
`timescale 1ns/1ps
`include "dch_defines.svh"
module testbench;
  localparam int HOME_LO = 3172; // index at 3072 plus shift of 100
  logic        mclk      = 1'b0;
  logic        rst_b     = 1'b0;
  logic        sel_auto  = 1'b1;
  logic [2:0]  tsel      = 3'h0;
  logic        prog_mode = 1'b0;
  logic        prog_cmd  = 1'b0;
  logic        start     = 1'b0;
  logic [11:0] cfg       = 12'h017;
  logic [15:0] hs        = 16'h0008;
  logic [15:0] cs        = 16'h0002;
  logic [15:0] tc        = 16'h0001;
  logic [31:0] shift     = 32'h0000_0064;
  logic [31:0] hpos      = 32'h0000_1234;
  logic [3:0]  filt      = 4'h1;
  logic        load      = 1'b1;
  logic [31:0] load_val  = 32'h0000_0000;
  logic        dog_en    = 1'b1;
  logic        ce        = 1'b1;
  logic        dog_inv   = 1'b0;
  logic        dog, fwd_lim, rev_lim, index, dir, moving, soft_en, home_done, ramp_bad;
  logic [31:0] axis_pos, cur_pos;
  logic [15:0] speed, max_speed, idx_speed;
  logic [11:0] warn;
  logic        first_dir, saw_rev, done_mv;
  int          soft_cnt;
  int          err_total = 0;
  int          n_checks  = 0;
  // ----------------------------------------------------------------
  // clock, design and axis
  // ----------------------------------------------------------------
  // 50 MHz clock
  always #10 mclk = ~mclk;
  dch_sequencer dch_sequencer_inst (
    .MCLK(mclk), .RST_B(rst_b), .CE(ce), .AUTO_MANUAL_SELECT(sel_auto),
    .TABLE_SELECT_BIT0(tsel[0]), .TABLE_SELECT_BIT1(tsel[1]), .TABLE_SELECT_BIT2(tsel[2]),
    .PROGRAM_MODE(prog_mode), .PROGRAM_HOME_RETURN_COMMAND(prog_cmd), .START(start),
    .PROXIMITY_DOG(dog ^ dog_inv), .FORWARD_STROKE_LIMIT(fwd_lim), .REVERSE_STROKE_LIMIT(rev_lim),
    .ENC_INDEX(index), .ENC_POSITION(axis_pos), .HOMING_METHOD_CONFIG(cfg),
    .HOMING_SPEED_SETTING(hs), .CREEP_SPEED_SETTING(cs), .HOME_SHIFT_DISTANCE(shift),
    .HOMING_ACCEL_TIME_CONSTANT(tc), .HOME_POSITION_VALUE(hpos), .INPUT_FILTER_TIME(filt),
    .SPEED_CMD(speed), .DIR_CMD(dir), .MOVING(moving), .SOFT_LIMIT_EN(soft_en),
    .HOME_DONE(home_done), .WARNING_CODE(warn), .CURRENT_POSITION(cur_pos));
  dch_axis_model dch_axis_model_inst (
    .clk(mclk), .speed(speed), .dir(dir), .load(load), .load_val(load_val), .dog_en(dog_en),
    .dog(dog), .fwd_lim(fwd_lim), .rev_lim(rev_lim), .index(index), .pos(axis_pos),
    .ramp_bad(ramp_bad), .max_speed(max_speed), .idx_speed(idx_speed));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // counted comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : check
  // counts and verdict
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // reset pulse, settings latched on release
  task automatic do_reset;
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    repeat (80) @(negedge mclk);
    check({31'h0, home_done}, 32'h0000_0000);
    check({31'h0, soft_en}, 32'h0000_0001);
  endtask : do_reset
  // place the axis, raise start, follow the motion to its end
  task automatic run_home(input logic [31:0] p, input logic go);
    int i;
    @(negedge mclk);
    load = 1'b1;
    load_val = p;
    @(negedge mclk);
    load = 1'b0;
    repeat (80) @(negedge mclk);
    start = 1'b1; // sensors settled through the filter first
    i = 0;
    while (moving !== 1'b1 && i < 200) begin
      @(negedge mclk);
      i++;
    end
    check({31'h0, moving}, {31'h0, go});
    start = 1'b0;
    first_dir = dir;
    saw_rev = 1'b0;
    done_mv = 1'b0;
    soft_cnt = 0;
    i = 0;
    while (moving === 1'b1 && i < 30000) begin
      saw_rev = saw_rev | !dir;
      done_mv = done_mv | home_done;
      if (soft_en !== 1'b0) soft_cnt++;
      @(negedge mclk);
      i++;
    end
    if (moving === 1'b1) begin
      check({31'h0, moving}, 32'h0000_0000);
      summarize();
    end
    repeat (80) @(negedge mclk);
  endtask : run_home
  // outcome of a completed homing
  task automatic judge_home;
    check({31'h0, home_done}, 32'h0000_0001);
    check({31'h0, done_mv}, 32'h0000_0000);
    check(cur_pos, hpos);
    check(($signed(axis_pos) >= HOME_LO && $signed(axis_pos) <= HOME_LO + 40) ? 32'h1 : 32'h0, 32'h1);
    check({16'h0, max_speed}, {16'h0, hs});
    check({16'h0, idx_speed}, {16'h0, cs});
    check({31'h0, ramp_bad}, 32'h0000_0000);
    check((soft_cnt <= 1) ? 32'h1 : 32'h0, 32'h1);
    check({20'h0, warn}, 32'h0000_0000);
  endtask : judge_home
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // two back-to-back homings from before the dog
  task automatic t_normal;
    for (int k = 0; k < 2; k++) begin
      run_home(32'h0000_0000, 1'b1);
      judge_home();
      check({31'h0, first_dir}, 32'h0000_0001);
    end
  endtask : t_normal
  // clock enable low in mid-motion freezes the sequencer
  task automatic t_freeze;
    logic [31:0] p0;
    logic [15:0] s0;
    fork
      run_home(32'h0000_0000, 1'b1);
      begin
        for (int i = 0; i < 400 && moving !== 1'b1; i++) @(negedge mclk);
        repeat (100) @(negedge mclk);
        p0 = cur_pos;
        s0 = speed;
        ce = 1'b0;
        repeat (20) @(negedge mclk);
        check(cur_pos, p0);
        check({16'h0, speed}, {16'h0, s0});
        ce = 1'b1;
      end
    join
    judge_home();
  endtask : t_freeze
  // start while sitting on the dog
  task automatic t_on_dog;
    run_home(32'h0000_09C4, 1'b1);
    judge_home();
  endtask : t_on_dog
  // start beyond the dog: limit, reverse, pass the dog, home
  task automatic t_beyond;
    run_home(32'h0000_1388, 1'b1);
    check({31'h0, first_dir}, 32'h0000_0001);
    check({31'h0, saw_rev}, 32'h0000_0001);
    judge_home();
  endtask : t_beyond
  // no dog at all: ends at the opposite limit with the warning
  task automatic t_no_dog;
    dog_en = 1'b0;
    run_home(32'h0000_1388, 1'b1);
    check({20'h0, warn}, {20'h0, `DCH_WARN_INCOMPLETE});
    check({31'h0, home_done}, 32'h0000_0000);
    check(($signed(axis_pos) <= -2000) ? 32'h1 : 32'h0, 32'h1);
    dog_en = 1'b1;
  endtask : t_no_dog
  // selection inputs, method digit and power-cycle latching
  task automatic t_select;
    cfg = 12'h016;
    run_home(32'h0000_0000, 1'b1);
    judge_home();
    cfg = 12'h017;
    tsel = 3'h1;
    run_home(32'h0000_0000, 1'b0);
    tsel = 3'h0;
    prog_mode = 1'b1;
    run_home(32'h0000_0000, 1'b0);
    prog_cmd = 1'b1;
    run_home(32'h0000_0000, 1'b1);
    judge_home();
    prog_mode = 1'b0;
    prog_cmd = 1'b0;
    cfg = 12'h016;
    do_reset();
    run_home(32'h0000_0000, 1'b0);
    cfg = 12'h017;
    run_home(32'h0000_0000, 1'b0);
    do_reset();
    run_home(32'h0000_0000, 1'b1);
    judge_home();
    cfg = 12'h117;
    dog_inv = 1'b1;
    do_reset();
    run_home(32'h0000_0000, 1'b1);
    judge_home();
  endtask : t_select
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  // reset, scenarios, verdict
  initial begin
    do_reset();
    t_normal();
    t_freeze();
    t_on_dog();
    t_beyond();
    t_no_dog();
    t_select();
    summarize();
  end
endmodule : testbench
